/* rtl/ofr_pkg.sv */
// Purpose: shared constants and types of the output fault response unit
// Assumes: 20 MHz core clock, byte-wide command port
// Notes:   response byte = code[7:6], retry[5:3], delay[2:0]
package ofr_pkg;

   // ---------------------------------------------------------------
   // timing
   // ---------------------------------------------------------------
   localparam int CLK_NS      = 50;
   localparam int V_STEP_NS   = 10000;                  // 10 us per step
   localparam int OC_STEP_MS  = 16;                     // 16 ms per step
   localparam int MS_NS       = 1000000;
   localparam int V_STEP_CYC  = V_STEP_NS / CLK_NS;
   localparam int OC_STEP_CYC = OC_STEP_MS * MS_NS / CLK_NS;
   localparam int MS_CYC      = MS_NS / CLK_NS;

   // ---------------------------------------------------------------
   // command codes and reset values
   // ---------------------------------------------------------------
   localparam logic [7:0] CMD_OV = 8'h41;
   localparam logic [7:0] CMD_UV = 8'h45;
   localparam logic [7:0] CMD_OC = 8'h47;
   localparam logic [7:0] RST_OV = 8'hB8;
   localparam logic [7:0] RST_UV = 8'hB8;
   localparam logic [7:0] RST_OC = 8'h00;

   // ---------------------------------------------------------------
   // response field encodings
   // ---------------------------------------------------------------
   localparam logic [1:0] CODE_IGN    = 2'h0;
   localparam logic [1:0] CODE_DLY_V  = 2'h1;
   localparam logic [1:0] CODE_IMM_V  = 2'h2;
   localparam logic [1:0] CODE_BAD_V  = 2'h3;
   localparam logic [1:0] CODE_DLY_OC = 2'h2;
   localparam logic [1:0] CODE_IMM_OC = 2'h3;
   localparam logic [1:0] CODE_RB     = 2'h2;            // delay shown on read
   localparam logic [2:0] RETRY_ALL   = 3'h7;
   localparam logic [2:0] DLY_ZERO    = 3'h0;

   // ---------------------------------------------------------------
   // fault indices and widths
   // ---------------------------------------------------------------
   localparam int NF    = 3;
   localparam int FI_UV = 0;
   localparam int FI_OV = 1;
   localparam int FI_OC = 2;
   localparam int TW    = 22;
   localparam int RW    = 32;

   typedef enum logic [2:0] {
      ST_ON   = 3'h1,
      ST_WAIT = 3'h2,
      ST_OFF  = 3'h4
   } ofr_st_e;

   typedef struct packed {
      logic [1:0] code;
      logic [2:0] retry;
      logic [2:0] dly;
   } ofr_resp_s;

   typedef struct packed {
      logic sb_vout_ov;
      logic sb_iout_oc;
      logic sw_vout;
      logic sw_iout;
      logic sv_ov;
      logic sv_uv;
      logic si_oc;
      logic cml;
   } ofr_flags_s;

   typedef struct packed {
      logic clear_faults;
      logic restore_all;
      logic device_soft_reset_command;
      logic w1c_ov;
      logic w1c_uv;
      logic w1c_oc;
      logic w1c_cml;
   } ofr_clr_s;

   typedef struct packed {
      ofr_st_e               st;
      logic [NF-1:0][7:0]    cfg;
      logic [NF-1:0][TW-1:0] tmr;
      logic [RW-1:0]         rcnt;
      ofr_flags_s            flg;
      logic                  alert_n;
      logic                  out_en;
      logic                  cmd_prev;
      logic [7:0]            rdata;
      logic                  rvalid;
   } ofr_state_s;

endpackage : ofr_pkg

/* rtl/ofr_top.sv */
// Purpose: fault response for one output channel (uv, ov, oc)
// Assumes: inputs synchronous to core_clk, command port decoded upstream
// Notes:   all state in one struct, one comb and one clocked process
module ofr_top
   import ofr_pkg::*;
#(
   parameter int OC_STEP_CYC_P = OC_STEP_CYC,
   parameter int MS_CYC_P      = MS_CYC
) (
   input  wire logic        core_clk,
   input  wire logic        rst_n,
   input  wire logic        ce,
   input  wire logic        cmd_wr,
   input  wire logic        cmd_rd,
   input  wire logic [7:0]  cmd_code,
   input  wire logic [7:0]  cmd_wdata,
   input  wire ofr_clr_s    clr,
   input  wire logic        out_cmd,
   input  wire logic        ramping,
   input  wire logic        uv_fault,
   input  wire logic        ov_fault,
   input  wire logic        oc_fault,
   input  wire logic [2:0]  alert_mask,
   input  wire logic [15:0] retry_interval_setting,
   output logic             out_en,
   output logic             alert_n,
   output ofr_flags_s       flags,
   output logic [7:0]       rdata,
   output logic             rvalid
);

   // ---------------------------------------------------------------
   // helpers
   // ---------------------------------------------------------------
   // read view of a response byte
   function automatic logic [7:0] rb_view(input logic [7:0] v);
      ofr_resp_s r;
      r = v;
      if (r.code != CODE_RB) begin
         r.dly = DLY_ZERO;
      end
      return r;
   endfunction : rb_view

   // delayed no-restart with endless retry is contradictory
   function automatic logic oc_bad(input logic [7:0] v);
      ofr_resp_s r;
      r = v;
      return (r.code == CODE_DLY_OC) && (r.retry == RETRY_ALL);
   endfunction : oc_bad

   // reset image of the whole state
   localparam ofr_state_s S_RST = '{
      st: ST_ON, cfg: {RST_OC, RST_OV, RST_UV}, tmr: '0, rcnt: '0,
      flg: '0, alert_n: 1'b1, out_en: 1'b0, cmd_prev: 1'b0,
      rdata: 8'h00, rvalid: 1'b0};

   // state copies and comb working values
   ofr_state_s            s_q;
   ofr_state_s            s_d;
   logic [NF-1:0]         fvec;
   logic [NF-1:0][TW-1:0] lim;
   logic [RW-1:0]         retry_lim;
   logic                  clr_all;
   logic                  shut_nr;
   logic                  shut_rt;
   logic                  cml_set;
   logic                  new_evt;
   ofr_resp_s             c;
   logic                  vol;
   logic                  armed;
   logic                  act;

   // ---------------------------------------------------------------
   // outputs straight from state
   // ---------------------------------------------------------------
   assign out_en  = s_q.out_en;
   assign alert_n = s_q.alert_n;
   assign flags   = s_q.flg;
   assign rdata   = s_q.rdata;
   assign rvalid  = s_q.rvalid;

   // overcurrent blanked while ramping
   assign fvec      = {oc_fault & ~ramping, ov_fault, uv_fault};
   assign retry_lim = RW'(retry_interval_setting) * RW'(MS_CYC_P);
   assign clr_all   = clr.clear_faults | clr.restore_all
                    | clr.device_soft_reset_command
                    | (out_cmd & ~s_q.cmd_prev);

   // ---------------------------------------------------------------
   // next state
   // ---------------------------------------------------------------
   always_comb begin
      s_d      = s_q;
      shut_nr  = 1'b0;
      shut_rt  = 1'b0;
      cml_set  = 1'b0;
      lim      = '0;
      c        = '0;
      vol      = 1'b0;
      armed    = 1'b0;
      s_d.cmd_prev = out_cmd;
      act      = out_cmd && (s_q.st != ST_OFF);

      // response byte writes
      if (clr.restore_all || clr.device_soft_reset_command) begin
         s_d.cfg = S_RST.cfg;
      end else if (cmd_wr) begin
         case (cmd_code)
            CMD_UV, CMD_OV: begin
               if (cmd_wdata[7:6] == CODE_BAD_V) begin
                  cml_set = 1'b1;
               end else if (cmd_code == CMD_UV) begin
                  s_d.cfg[FI_UV] = cmd_wdata;
               end else begin
                  s_d.cfg[FI_OV] = cmd_wdata;
               end
            end
            CMD_OC: begin
               if (oc_bad(cmd_wdata)) begin
                  cml_set = 1'b1;
               end else begin
                  s_d.cfg[FI_OC] = cmd_wdata;
               end
            end
            default: cml_set = 1'b1;                            // unknown code
         endcase
      end

      // readback, one cycle later
      s_d.rvalid = cmd_rd;
      if (cmd_rd) begin
         case (cmd_code)
            CMD_UV:  s_d.rdata = rb_view(s_q.cfg[FI_UV]);
            CMD_OV:  s_d.rdata = rb_view(s_q.cfg[FI_OV]);
            CMD_OC:  s_d.rdata = rb_view(s_q.cfg[FI_OC]);
            default: s_d.rdata = 8'h00;
         endcase
      end

      // per fault delay timers and shutdown requests
      for (int i = 0; i < NF; i++) begin
         c   = s_q.cfg[i];
         vol = (i != FI_OC);
         lim[i] = TW'(c.dly) * (vol ? TW'(V_STEP_CYC)
                                    : TW'(OC_STEP_CYC_P));
         armed = fvec[i] && (c.code == (vol ? CODE_DLY_V : CODE_DLY_OC));
         if (!armed || (s_q.st != ST_ON) || !out_cmd) begin
            s_d.tmr[i] = '0;
         end else if (s_q.tmr[i] < lim[i]) begin
            s_d.tmr[i] = s_q.tmr[i] + TW'(1);
         end
         // delayed shutdown never restarts
         if (armed && (s_q.st == ST_ON) && (s_q.tmr[i] >= lim[i])) begin
            shut_nr = 1'b1;
         end
         // immediate shutdown follows retry field
         if (fvec[i] && (c.code == (vol ? CODE_IMM_V : CODE_IMM_OC))) begin
            if (c.retry == RETRY_ALL) begin
               shut_rt = 1'b1;
            end else begin
               shut_nr = 1'b1;
            end
         end
      end

      // output control
      case (s_q.st)
         ST_ON: begin
            if (act && shut_nr) begin
               s_d.st = ST_OFF;
            end else if (act && shut_rt) begin
               s_d.st   = ST_WAIT;
               s_d.rcnt = '0;
            end
         end
         ST_WAIT: begin
            if (!out_cmd) begin
               s_d.st = ST_ON;
            end else if (shut_nr) begin
               s_d.st = ST_OFF;
            end else if (s_q.rcnt >= retry_lim) begin
               s_d.st = ST_ON;
            end else begin
               s_d.rcnt = s_q.rcnt + RW'(1);
            end
         end
         ST_OFF: begin
            if (clr_all) begin
               s_d.st = ST_ON;
            end
         end
         default: s_d.st = ST_ON;
      endcase
      s_d.out_en = (s_d.st == ST_ON) && out_cmd;

      // sticky status, set beats clear
      s_d.flg.sv_uv = fvec[FI_UV] |
                      (s_q.flg.sv_uv & ~clr_all & ~clr.w1c_uv);
      s_d.flg.sv_ov = fvec[FI_OV] |
                      (s_q.flg.sv_ov & ~clr_all & ~clr.w1c_ov);
      s_d.flg.si_oc = fvec[FI_OC] |
                      (s_q.flg.si_oc & ~clr_all & ~clr.w1c_oc);
      s_d.flg.cml   = cml_set |
                      (s_q.flg.cml & ~clr_all & ~clr.w1c_cml);
      s_d.flg.sb_vout_ov = s_d.flg.sv_ov;
      s_d.flg.sw_vout    = s_d.flg.sv_ov | s_d.flg.sv_uv;
      s_d.flg.sb_iout_oc = s_d.flg.si_oc;
      s_d.flg.sw_iout    = s_d.flg.si_oc;

      // alert on newly latched unmasked event, held while flags stand
      new_evt = (fvec[FI_UV] & ~alert_mask[FI_UV] & ~s_q.flg.sv_uv)
              | (fvec[FI_OV] & ~alert_mask[FI_OV] & ~s_q.flg.sv_ov)
              | (fvec[FI_OC] & ~alert_mask[FI_OC] & ~s_q.flg.si_oc)
              | (cml_set & ~s_q.flg.cml);
      s_d.alert_n = ~(new_evt | (~s_q.alert_n & (|s_d.flg)));
   end

   // ---------------------------------------------------------------
   // state register
   // ---------------------------------------------------------------
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         s_q <= S_RST;
      end else if (ce) begin
         s_q <= s_d;
      end
   end

   // ---------------------------------------------------------------
   // assertions
   // ---------------------------------------------------------------
   ofr_resp_s cfg_uv;
   ofr_resp_s cfg_ov;
   ofr_resp_s cfg_oc;
   assign cfg_uv = s_q.cfg[FI_UV];
   assign cfg_ov = s_q.cfg[FI_OV];
   assign cfg_oc = s_q.cfg[FI_OC];

   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (!rst_n);

   a_uv_status_set: assert property (ce && uv_fault |=>
      flags.sv_uv && flags.sw_vout) else $error("uv status not set");
   a_ov_status_set: assert property (ce && ov_fault |=>
      flags.sv_ov && flags.sb_vout_ov && flags.sw_vout)
      else $error("ov status not set");
   a_alert_new_uv: assert property (
      ce && uv_fault && !alert_mask[FI_UV] && !flags.sv_uv |=> !alert_n)
      else $error("alert missing on uv");
   a_flag_sticky: assert property (
      ce && flags.sv_uv && !clr_all && !clr.w1c_uv |=> flags.sv_uv)
      else $error("uv flag dropped");
   a_ignore_runs: assert property (
      ce && s_q.st == ST_ON && cfg_uv.code == CODE_IGN
      && cfg_oc.code[1] == 1'b0 && cfg_ov.code == CODE_IGN
      |=> s_q.st == ST_ON) else $error("ignore code shut output");
   a_v_delay_shut: assert property (
      ce && s_q.st == ST_ON && out_cmd && uv_fault && cfg_uv.code == CODE_DLY_V
      && s_q.tmr[FI_UV] >= lim[FI_UV] |=> s_q.st == ST_OFF && !out_en)
      else $error("uv delayed shutdown missed");
   a_v_imm_shut: assert property (
      ce && s_q.st == ST_ON && out_cmd && uv_fault && cfg_uv.code == CODE_IMM_V
      |=> !out_en && s_q.st != ST_ON) else $error("uv immediate shutdown missed");
   a_v_bad_code: assert property (
      ce && cmd_wr && cmd_code == CMD_UV && cmd_wdata[7:6] == CODE_BAD_V
      && !clr.restore_all && !clr.device_soft_reset_command
      |=> flags.cml) else $error("no logic fault on bad code");
   a_off_holds: assert property (
      ce && s_q.st == ST_OFF && !clr_all |=> s_q.st == ST_OFF && !out_en)
      else $error("restart without clear");
   a_retry_waits: assert property (
      ce && s_q.st == ST_WAIT && out_cmd && s_q.rcnt < retry_lim
      |=> !out_en) else $error("retry before interval");
   a_v_step_size: assert property (
      cfg_uv.dly == 3'h1 |-> lim[FI_UV] == TW'(200))
      else $error("voltage step wrong");
   a_rb_delay_zero: assert property (
      ce && cmd_rd && cmd_code == CMD_UV && cfg_uv.code != CODE_RB
      |=> rvalid && rdata[2:0] == 3'h0) else $error("delay not masked");
   a_oc_status_set: assert property (
      ce && oc_fault && !ramping |=> flags.si_oc && flags.sb_iout_oc
      && flags.sw_iout) else $error("oc status not set");
   a_oc_ramp_blank: assert property (
      ce && ramping && !flags.si_oc |=> !flags.si_oc)
      else $error("oc seen during ramp");
   a_oc_delay_shut: assert property (
      ce && s_q.st == ST_ON && out_cmd && fvec[FI_OC]
      && cfg_oc.code == CODE_DLY_OC && s_q.tmr[FI_OC] >= lim[FI_OC]
      |=> s_q.st == ST_OFF) else $error("oc delayed shutdown missed");
   a_oc_imm_shut: assert property (
      ce && s_q.st == ST_ON && out_cmd && fvec[FI_OC]
      && cfg_oc.code == CODE_IMM_OC |=> !out_en)
      else $error("oc immediate shutdown missed");
   a_oc_step_size: assert property (
      cfg_oc.dly == 3'h1 |-> lim[FI_OC] == TW'(OC_STEP_CYC_P))
      else $error("oc step wrong");
   a_oc_bad_kept: assert property (
      ce && cmd_wr && cmd_code == CMD_OC && oc_bad(cmd_wdata)
      && !clr.restore_all && !clr.device_soft_reset_command
      |=> cfg_oc == $past(cfg_oc) && flags.cml) else $error("bad oc write kept");
   a_timer_restart: assert property (
      ce && !uv_fault |=> s_q.tmr[FI_UV] == '0) else $error("timer not restarted");
   a_oc_alert_new: assert property (
      ce && oc_fault && !ramping && !alert_mask[FI_OC] && !flags.si_oc |=> !alert_n)
      else $error("alert missing on oc");
   a_cml_alert: assert property (
      ce && cml_set && !flags.cml |=> !alert_n) else $error("alert missing on logic fault");
   a_retry_resume: assert property (
      ce && s_q.st == ST_WAIT && out_cmd && !shut_nr && s_q.rcnt >= retry_lim
      |=> s_q.st == ST_ON && out_en) else $error("retry did not resume");
   // ce low freezes every register
   a_ce_freeze: assert property (!ce |=> $stable(s_q))
      else $error("state moved while frozen");

   // main scenarios reached
   c_delay_shut: cover property (ce && s_q.st == ST_ON ##1 s_q.st == ST_OFF);
   c_retry_cycle: cover property (s_q.st == ST_WAIT ##[1:1000] s_q.st == ST_ON);
   c_clear_restart: cover property (s_q.st == ST_OFF ##1 s_q.st == ST_ON);
   c_masked_fault: cover property (ce && ov_fault && alert_mask[FI_OV]);
   c_ramp_blank: cover property (ce && ramping && oc_fault);

endmodule : ofr_top

/* verification/ofr_host.sv */
// Purpose: host model on the command port, drives byte writes and read strobes
// Assumes: drives at the falling edge, one-cycle strobes
// Notes:   released write data shows the inverse of the last byte
module ofr_host
   import ofr_pkg::*;
(
   input  wire logic       core_clk,
   output logic            cmd_wr,
   output logic            cmd_rd,
   output logic [7:0]      cmd_code,
   output logic [7:0]      cmd_wdata
);
   timeunit 1ns;
   timeprecision 1ns;

   initial begin
      cmd_wr    = 1'b0;
      cmd_rd    = 1'b0;
      cmd_code  = 8'h00;
      cmd_wdata = 8'h00;
   end

   // ----------------------------------------------------------------
   // byte write and read strobes
   // ----------------------------------------------------------------
   task automatic wr(input logic [7:0] c, input logic [7:0] d);
      @(negedge core_clk);
      cmd_code  <= c;
      cmd_wdata <= d;
      cmd_wr    <= 1'b1;
      @(negedge core_clk);
      cmd_wr    <= 1'b0;
      cmd_wdata <= ~d;   // no stale byte after release
   endtask : wr

   task automatic rd(input logic [7:0] c);
      @(negedge core_clk);
      cmd_code <= c;
      cmd_rd   <= 1'b1;
      @(negedge core_clk);
      cmd_rd   <= 1'b0;
      cmd_code <= ~c;
   endtask : rd
endmodule : ofr_host

/* verification/tb.sv */
// Purpose: self-checking bench for the output fault response unit
// Assumes: short step parameters, 50 ns clock
// Notes:   reads are checked from a queue of expected bytes
module tb
   import ofr_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;

   logic             core_clk = 1'b0;
   logic             rst_n    = 1'b0;
   logic             ce       = 1'b1;
   logic             cmd_wr, cmd_rd;
   logic [7:0]       cmd_code, cmd_wdata;
   ofr_clr_s         clr      = '0;
   logic             out_cmd  = 1'b1;
   logic             ramping  = 1'b0;
   logic             uv_fault = 1'b0;
   logic             ov_fault = 1'b0;
   logic             oc_fault = 1'b0;
   logic [2:0]       alert_mask = 3'h0;
   logic [15:0]      retry_interval_setting = 16'h0002;
   logic             out_en, alert_n, rvalid;
   ofr_flags_s       flags;
   logic [7:0]       rdata;
   logic [7:0]       exp_q[$];
   logic [2:0]       rt;
   int               seed = 37;
   int               n_fail = 0;
   int               samples_checked = 0;

   always #25 core_clk = ~core_clk;

   ofr_top #(.OC_STEP_CYC_P(20), .MS_CYC_P(10)) DUT (
      .core_clk(core_clk), .rst_n(rst_n), .ce(ce), .cmd_wr(cmd_wr), .cmd_rd(cmd_rd),
      .cmd_code(cmd_code), .cmd_wdata(cmd_wdata), .clr(clr), .out_cmd(out_cmd),
      .ramping(ramping), .uv_fault(uv_fault), .ov_fault(ov_fault), .oc_fault(oc_fault),
      .alert_mask(alert_mask), .retry_interval_setting(retry_interval_setting),
      .out_en(out_en), .alert_n(alert_n), .flags(flags), .rdata(rdata), .rvalid(rvalid));

   ofr_host host (
      .core_clk(core_clk), .cmd_wr(cmd_wr), .cmd_rd(cmd_rd),
      .cmd_code(cmd_code), .cmd_wdata(cmd_wdata));

   // ----------------------------------------------------------------
   // compare, finish and helpers
   // ----------------------------------------------------------------
   task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string m);
      samples_checked++;
      if (got !== exp) begin
         n_fail++;
         $display("mismatch at %0t: %s got %h exp %h", $time, m, got, exp);
      end
   endtask : chk

   task automatic test_done();
      if (exp_q.size() != 0) begin
         n_fail++;                                 // read answer never came
      end
      $display("checks %0d mismatches %0d", samples_checked, n_fail);
      if (n_fail == 0 && samples_checked > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : test_done

   task automatic cyc(input int n);
      repeat (n) @(negedge core_clk);
   endtask : cyc

   task automatic rd_exp(input logic [7:0] c, input logic [7:0] e);
      exp_q.push_back(e);
      host.rd(c);
      cyc(2);
   endtask : rd_exp

   task automatic pulse(input logic [6:0] c);
      @(negedge core_clk);
      clr <= c;
      @(negedge core_clk);
      clr <= '0;
      cyc(2);
   endtask : pulse

   // status, alert and enable in one go
   task automatic st(input logic [7:0] f, input logic a, input logic e);
      chk(flags, f, "flags");
      chk({7'h0, alert_n}, {7'h0, a}, "alert_n");
      chk({7'h0, out_en}, {7'h0, e}, "out_en");
   endtask : st

   // oldest expected byte against each read answer
   always @(negedge core_clk) begin
      if (rvalid === 1'b1) begin
         if (exp_q.size() == 0) begin
            chk(rdata, 8'hxx, "unexpected read");
         end else begin
            chk(rdata, exp_q.pop_front(), "read");
         end
      end
   end

   // watchdog
   initial begin
      repeat (20000) @(posedge core_clk);
      n_fail++;
      test_done();
   end

   // ----------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------
   initial begin
      cyc(6);
      rst_n <= 1'b1;
      cyc(3);
      // reset values and readback masking
      rd_exp(CMD_UV, 8'hB8);
      rd_exp(CMD_OV, 8'hB8);
      rd_exp(CMD_OC, 8'h00);
      host.wr(CMD_UV, 8'h47);
      rd_exp(CMD_UV, 8'h40);
      // write while frozen by the clock enable is lost
      ce <= 1'b0;
      host.wr(CMD_UV, 8'h80);
      ce <= 1'b1;
      rd_exp(CMD_UV, 8'h40);
      rd_exp(8'h99, 8'h00);
      // refused writes
      host.wr(CMD_OV, 8'hC0);
      cyc(2);
      st(8'h01, 1'b0, 1'b1);
      rd_exp(CMD_OV, 8'hB8);
      pulse(7'b1000000);
      st(8'h00, 1'b1, 1'b1);
      host.wr(CMD_OC, 8'hB8);
      cyc(2);
      st(8'h01, 1'b0, 1'b1);
      rd_exp(CMD_OC, 8'h00);
      pulse(7'b0000001);
      st(8'h00, 1'b1, 1'b1);
      // undervoltage immediate, random no-retry setting
      rt = 3'($unsigned($random(seed)) % 7);
      host.wr(CMD_UV, {2'b10, rt, 3'b000});
      rd_exp(CMD_UV, {2'b10, rt, 3'b000});
      uv_fault <= 1'b1;
      cyc(1);
      uv_fault <= 1'b0;
      cyc(3);
      st(8'h24, 1'b0, 1'b0);
      cyc(100);
      st(8'h24, 1'b0, 1'b0);
      pulse(7'b1000000);
      st(8'h00, 1'b1, 1'b1);
      // overvoltage ignored, alert masked
      host.wr(CMD_OV, 8'h00);
      alert_mask <= 3'h2;
      ov_fault   <= 1'b1;
      cyc(20);
      st(8'hA8, 1'b1, 1'b1);
      ov_fault <= 1'b0;
      pulse(7'b0001000);
      st(8'h00, 1'b1, 1'b1);
      alert_mask <= 3'h0;
      // undervoltage delayed two steps, interrupted once
      host.wr(CMD_UV, 8'h42);
      uv_fault <= 1'b1;
      cyc(300);
      uv_fault <= 1'b0;
      cyc(1);
      uv_fault <= 1'b1;
      cyc(395);
      chk({7'h0, out_en}, 8'h01, "delay early");
      cyc(15);
      chk({7'h0, out_en}, 8'h00, "delay end");
      uv_fault <= 1'b0;
      cyc(50);
      st(8'h24, 1'b0, 1'b0);
      pulse(7'b1000000);
      st(8'h00, 1'b1, 1'b1);
      // overcurrent during ramp, then delayed one step
      host.wr(CMD_OC, 8'h81);
      ramping  <= 1'b1;
      oc_fault <= 1'b1;
      cyc(50);
      st(8'h00, 1'b1, 1'b1);
      ramping <= 1'b0;
      cyc(15);
      chk({7'h0, out_en}, 8'h01, "oc early");
      cyc(15);
      st(8'h52, 1'b0, 1'b0);
      oc_fault <= 1'b0;
      cyc(40);
      chk({7'h0, out_en}, 8'h00, "oc stays off");
      out_cmd <= 1'b0;
      cyc(4);
      out_cmd <= 1'b1;
      cyc(3);
      st(8'h00, 1'b1, 1'b1);
      // overcurrent shutdown with endless retry
      host.wr(CMD_OC, 8'hF8);
      oc_fault <= 1'b1;
      cyc(2);
      oc_fault <= 1'b0;
      cyc(2);
      st(8'h52, 1'b0, 1'b0);
      cyc(40);
      st(8'h52, 1'b0, 1'b1);
      pulse(7'b0000010);
      st(8'h00, 1'b1, 1'b1);
      // soft reset clears a flag and restores the defaults
      uv_fault <= 1'b1;
      cyc(1);
      uv_fault <= 1'b0;
      cyc(2);
      st(8'h24, 1'b0, 1'b1);
      pulse(7'b0010000);
      st(8'h00, 1'b1, 1'b1);
      rd_exp(CMD_UV, 8'hB8);
      rd_exp(CMD_OV, 8'hB8);
      // restore command also brings back the response bytes
      host.wr(CMD_OC, 8'h81);
      pulse(7'b0100000);
      rd_exp(CMD_OC, 8'h00);
      cyc(5);
      test_done();
   end
endmodule : tb
